// ---- design/trace_port.sv ----
// branch trace and ram monitor debug port with axi4-lite control
`timescale 1ns/1ps
`include "trace_port_defs.svh"
module trace_port (
  input wire logic aclk,
  input wire logic aresetn,
  // core side
  input wire logic branch_valid,
  input wire logic [31:0] branch_target,
  output trace_port_pkg::mem_req_type mem_req,
  output logic mem_req_valid,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  // debug pins
  input wire logic debug_reset_n,
  input wire logic debug_mode_select,
  input wire logic debug_link_clock_in,
  output logic debug_link_clock_out,
  output logic debug_link_clock_oe,
  input wire logic frame_sync_n_in,
  output logic frame_sync_n_out,
  output logic frame_sync_n_oe,
  input wire logic [3:0] debug_nibble_bus_in,
  output logic [3:0] debug_nibble_bus_out,
  output logic debug_nibble_bus_oe,
  // axi4-lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // size code from the match of upper bits against compare value
  // one, two, four or eight nibble codes
  function automatic logic [1:0] size_code(input logic [31:0] a, input logic [31:0] c);
    if (a[31:4] == c[31:4]) size_code = `SZ_4;
    else if (a[31:8] == c[31:8]) size_code = `SZ_8;
    else if (a[31:16] == c[31:16]) size_code = `SZ_16;
    else size_code = `SZ_32;
  endfunction : size_code

  // nibble count for a trace size code or an access size
  function automatic logic [3:0] nib_count(input logic [1:0] sc, input logic acc);
    if (acc) nib_count = (sc == `ACC_BYTE) ? 4'h2 : (sc == `ACC_WORD) ? 4'h4 : 4'h8;
    else nib_count = (sc == `SZ_4) ? 4'h1 : (sc == `SZ_8) ? 4'h2 :
      (sc == `SZ_16) ? 4'h4 : 4'h8;
  endfunction : nib_count

  // pin synchronisers, two stages each
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  always_ff @(posedge aclk) begin
    pin_s1_r <= {debug_reset_n, debug_mode_select, debug_link_clock_in,
      frame_sync_n_in, debug_nibble_bus_in};
    pin_s2_r <= pin_s1_r;
  end
  logic drst_n_s;
  logic mode_s;
  logic lck_s;
  logic fs_n_s;
  logic [3:0] nib_s;
  assign {drst_n_s, mode_s, lck_s, fs_n_s, nib_s} = pin_s2_r;

  // port reset from system or debug reset
  logic prst;
  assign prst = !aresetn || !drst_n_s;

  // mode caught while debug reset is held
  logic mode_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= 1'b1;
    end else if (!drst_n_s) begin
      mode_r <= mode_s;
    end
  end

  // control register: single chip flag, trace enable
  logic [1:0] ctrl_r;

  // link clock edge detection in monitor mode
  logic lck_d_r;
  always_ff @(posedge aclk) begin
    if (prst) lck_d_r <= 1'b1;
    else lck_d_r <= lck_s;
  end
  logic lck_rise;
  logic lck_fall;
  assign lck_rise = lck_s && !lck_d_r;
  assign lck_fall = !lck_s && lck_d_r;

  // ---------------- branch trace ----------------
  logic lclk_r;
  logic pend_r;
  logic [31:0] pend_addr_r;
  logic [31:0] cmp_r;
  logic [31:0] tsh_r;
  logic [3:0] tcnt_r;
  logic tick;
  // update point: link clock about to fall
  assign tick = lclk_r && !mode_r;
  // first update point after a branch only arms the header
  logic arm_r;
  // header goes out on the second update point
  logic emit;
  assign emit = tick && pend_r && arm_r;

  always_ff @(posedge aclk) begin
    if (prst || mode_r) lclk_r <= 1'b0;
    else lclk_r <= !lclk_r;
  end

  // pending branch latch, newest wins
  always_ff @(posedge aclk) begin
    if (prst) begin
      pend_r <= 1'b0;
      arm_r <= 1'b0;
      pend_addr_r <= `CMP_INIT;
    end else if (branch_valid && !mode_r && ctrl_r[`CTRL_TRACE_EN]) begin
      pend_r <= 1'b1;
      arm_r <= 1'b0;
      pend_addr_r <= branch_target;
    // arm on one update point, emit on the next
    end else if (tick && pend_r) begin
      pend_r <= !arm_r;
      arm_r <= !arm_r;
    end
  end

  // trace shifter and nibble counter
  always_ff @(posedge aclk) begin
    if (prst) begin
      tsh_r <= `CMP_INIT;
      tcnt_r <= 4'h0;
    end else if (emit) begin
      tsh_r <= pend_addr_r;
      tcnt_r <= nib_count(size_code(pend_addr_r, cmp_r), 1'b0);
    end else if (tick && tcnt_r != 4'h0) begin
      tsh_r <= {4'h0, tsh_r[31:4]};
      tcnt_r <= tcnt_r - 4'h1;
    end
  end

  // compare value and source of the running transfer
  logic [31:0] cur_addr_r;
  always_ff @(posedge aclk) begin
    if (prst) begin
      cmp_r <= `CMP_INIT;
      cur_addr_r <= `CMP_INIT;
    end else if (emit) begin
      cur_addr_r <= pend_addr_r;
    end else if (tick && tcnt_r == 4'h1) begin
      cmp_r <= cur_addr_r;
    end
  end

  // ---------------- ram monitor ----------------
  trace_port_pkg::mon_state_type mst_r;
  logic [1:0] acc_r;
  logic wr_r;
  logic [31:0] maddr_r;
  logic [31:0] mwdata_r;
  logic [31:0] mrdata_r;
  logic [3:0] mcnt_r;
  logic [3:0] stat_r;
  logic issued_r;
  logic berr;

  assign berr = (acc_r == `ACC_WORD && maddr_r[0]) ||
    (acc_r == `ACC_LONG && maddr_r[1:0] != 2'h0) ||
    (acc_r == `ACC_LONG && (maddr_r & `IO8_MASK) == `IO8_BASE) ||
    (ctrl_r[`CTRL_SINGLE] && maddr_r >= `EXT_LIMIT &&
      (maddr_r & `IO8_MASK) != `IO8_BASE);

  // monitor sequencer
  always_ff @(posedge aclk) begin
    if (prst || !mode_r) begin
      mst_r <= trace_port_pkg::M_CMD;
      acc_r <= `ACC_BYTE;
      wr_r <= 1'b0;
      maddr_r <= 32'h00000000;
      mwdata_r <= 32'h00000000;
      mcnt_r <= 4'h0;
      stat_r <= `ST_BUSY;
    end else begin
      case (mst_r)
        // sample only with sync held low
        trace_port_pkg::M_CMD: begin
          if (lck_rise && !fs_n_s) begin
            acc_r <= nib_s[1:0];
            wr_r <= nib_s[2];
            maddr_r <= 32'h00000000;
            mwdata_r <= 32'h00000000;
            mcnt_r <= 4'h0;
            // command nibble holds dir and size
            if (nib_s[3:2] != `DIR_READ && nib_s[3:2] != `DIR_WRITE ||
                nib_s[1:0] == 2'h3) begin
              stat_r <= `ST_CMD_ERR;
              mst_r <= trace_port_pkg::M_STAT;
            end else begin
              stat_r <= `ST_BUSY;
              mst_r <= trace_port_pkg::M_ADDR;
            end
          end
        end
        trace_port_pkg::M_ADDR: begin
          if (lck_rise && !fs_n_s) begin
            maddr_r <= maddr_r | (32'(nib_s) << {mcnt_r, 2'b00});
            mcnt_r <= mcnt_r + 4'h1;
            if (mcnt_r == `ADDR_NIBS - 4'h1) begin
              mcnt_r <= 4'h0;
              mst_r <= wr_r ? trace_port_pkg::M_DATA : trace_port_pkg::M_BUSY;
            end
          end
        end
        trace_port_pkg::M_DATA: begin
          if (lck_rise && !fs_n_s) begin
            mwdata_r <= mwdata_r | (32'(nib_s) << {mcnt_r, 2'b00});
            mcnt_r <= mcnt_r + 4'h1;
            if (mcnt_r == nib_count(acc_r, 1'b1) - 4'h1) begin
              mcnt_r <= 4'h0;
              mst_r <= trace_port_pkg::M_BUSY;
            end
          end
        end
        trace_port_pkg::M_BUSY: begin
          if (berr) begin
            stat_r <= `ST_BUS_ERR;
            mst_r <= trace_port_pkg::M_STAT;
          end else if (mem_ack) begin
            stat_r <= mem_err ? `ST_BUS_ERR : `ST_READY;
            mst_r <= trace_port_pkg::M_STAT;
          end
        end
        trace_port_pkg::M_STAT: begin
          if (fs_n_s) begin
            mcnt_r <= 4'h0;
            mst_r <= (stat_r == `ST_READY && !wr_r) ?
              trace_port_pkg::M_RDAT : trace_port_pkg::M_CMD;
          end
        end
        trace_port_pkg::M_RDAT: begin
          if (lck_fall) begin
            mcnt_r <= mcnt_r + 4'h1;
            if (mcnt_r == nib_count(acc_r, 1'b1)) mst_r <= trace_port_pkg::M_CMD;
          end
        end
        default: mst_r <= trace_port_pkg::M_CMD;
      endcase
    end
  end

  // system bus request, held until acknowledged
  always_ff @(posedge aclk) begin
    if (prst || !mode_r) begin
      mem_req_valid <= 1'b0;
      mem_req <= '0;
      issued_r <= 1'b0;
    end else if (mst_r == trace_port_pkg::M_BUSY && !berr && !issued_r) begin
      mem_req_valid <= 1'b1;
      mem_req <= '{addr: maddr_r, wdata: mwdata_r, size: acc_r, write: wr_r};
      issued_r <= 1'b1;
    end else if (mem_ack) begin
      mem_req_valid <= 1'b0;
    end else if (mst_r != trace_port_pkg::M_BUSY) begin
      issued_r <= 1'b0;
    end
  end

  // read data capture
  always_ff @(posedge aclk) begin
    if (prst) mrdata_r <= 32'h00000000;
    else if (mst_r == trace_port_pkg::M_BUSY && mem_ack) mrdata_r <= mem_rdata;
  end

  // ---------------- pin drivers ----------------
  always_ff @(posedge aclk) begin
    if (prst) begin
      debug_link_clock_out <= 1'b0;
      debug_link_clock_oe <= 1'b0;
      frame_sync_n_out <= 1'b1;
      frame_sync_n_oe <= 1'b0;
      debug_nibble_bus_out <= `IDLE_NIB;
      debug_nibble_bus_oe <= 1'b0;
    end else if (!mode_r) begin
      // link clock falls where the nibble changes, tool samples on the rise
      debug_link_clock_out <= !lclk_r;
      debug_link_clock_oe <= 1'b1;
      frame_sync_n_oe <= 1'b1;
      debug_nibble_bus_oe <= 1'b1;
      if (tick) begin
        if (emit) begin
          // header on the second update point
          frame_sync_n_out <= 1'b1;
          debug_nibble_bus_out <= {`HDR_PREFIX, size_code(pend_addr_r, cmp_r)};
        end else if (tcnt_r != 4'h0) begin
          frame_sync_n_out <= 1'b0;
          debug_nibble_bus_out <= tsh_r[3:0];
        end else begin
          frame_sync_n_out <= 1'b1;
          debug_nibble_bus_out <= `IDLE_NIB;
        end
      end
    end else begin
      debug_link_clock_out <= 1'b0;
      debug_link_clock_oe <= 1'b0;
      frame_sync_n_out <= 1'b1;
      frame_sync_n_oe <= 1'b0;
      if (mst_r == trace_port_pkg::M_BUSY || mst_r == trace_port_pkg::M_STAT) begin
        debug_nibble_bus_oe <= 1'b1;
        debug_nibble_bus_out <= (mst_r == trace_port_pkg::M_BUSY) ? `ST_BUSY : stat_r;
      end else if (mst_r == trace_port_pkg::M_RDAT) begin
        debug_nibble_bus_oe <= 1'b1;
        if (lck_fall) debug_nibble_bus_out <= 4'(mrdata_r >> {mcnt_r, 2'b00});
      end else begin
        debug_nibble_bus_oe <= 1'b0;
        debug_nibble_bus_out <= `IDLE_NIB;
      end
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic wr_go;
  assign wr_go = s_awvalid && s_wvalid && !s_bvalid && !s_awready;

  // write channel: take address and data together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `AXI_OKAY;
      ctrl_r <= 2'h3;
    end else begin
      s_awready <= wr_go;
      s_wready <= wr_go;
      // answer only once both handshakes are done
      if (s_awready) begin
        s_bvalid <= 1'b1;
        s_bresp <= (s_awaddr == `OFF_CTRL) ? `AXI_OKAY : `AXI_SLVERR;
        if (s_awaddr == `OFF_CTRL && s_wstrb[0]) ctrl_r <= s_wdata[1:0];
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `AXI_OKAY;
    end else begin
      s_arready <= s_arvalid && !s_rvalid && !s_arready;
      // data follows the address handshake
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= `AXI_OKAY;
        case (s_araddr)
          `OFF_CTRL: s_rdata <= {30'h0, ctrl_r};
          `OFF_STATUS: s_rdata <= {21'h0, stat_r, 1'b0, mst_r, mode_r, pend_r,
            tcnt_r != 4'h0};
          `OFF_CMP: s_rdata <= cmp_r;
          default: begin
            s_rdata <= 32'h00000000;
            s_rresp <= `AXI_SLVERR;
          end
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule : trace_port

// ---- design/trace_port_defs.svh ----
// constants for the branch trace / ram monitor debug port
`ifndef TRACE_PORT_DEFS_SVH
`define TRACE_PORT_DEFS_SVH
`define IDLE_NIB 4'h3
`define HDR_PREFIX 2'h2
`define SZ_4 2'h0
`define SZ_8 2'h1
`define SZ_16 2'h2
`define SZ_32 2'h3
`define CMP_INIT 32'h00000000
`define ST_BUSY 4'h0
`define ST_READY 4'h1
`define ST_CMD_ERR 4'h2
`define ST_BUS_ERR 4'h4
`define DIR_READ 2'h2
`define DIR_WRITE 2'h3
`define ACC_BYTE 2'h0
`define ACC_WORD 2'h1
`define ACC_LONG 2'h2
`define ADDR_NIBS 4'h8
`define IO8_BASE 32'hFFFFF000
`define IO8_MASK 32'hFFFFF000
`define EXT_LIMIT 32'h00400000
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define OFF_CMP 4'h8
`define CTRL_SINGLE 0
`define CTRL_TRACE_EN 1
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ---- design/trace_port_pkg.sv ----
// types shared by the debug port design
package trace_port_pkg;
  // monitor sequence, gray coded along the usual path
  typedef enum logic [2:0] {
    M_CMD = 3'h0,
    M_ADDR = 3'h1,
    M_DATA = 3'h3,
    M_BUSY = 3'h2,
    M_STAT = 3'h6,
    M_RDAT = 3'h7
  } mon_state_type;
  // one access request toward the system bus
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic write;
  } mem_req_type;
endpackage : trace_port_pkg

// ---- test/trace_port_assertions.sv ----
// checker for debug port pin and bus timing
`timescale 1ns/1ps
module trace_port_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_reset_n,
  input wire trace_port_pkg::mem_req_type mem_req,
  input wire logic mem_req_valid,
  input wire logic mem_ack,
  input wire logic debug_link_clock_out,
  input wire logic debug_link_clock_oe,
  input wire logic frame_sync_n_out,
  input wire logic frame_sync_n_oe,
  input wire logic [3:0] debug_nibble_bus_out,
  input wire logic debug_nibble_bus_oe,
  input wire logic s_awvalid,
  input wire logic s_wvalid,
  input wire logic s_awready,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // device drives the trace pins
  logic trc;
  // header nibble on the bus
  logic hdr;
  // cycles with sync held low
  logic [4:0] low_cnt_r;
  assign trc = frame_sync_n_oe && debug_nibble_bus_oe;
  assign hdr = trc && frame_sync_n_out && debug_nibble_bus_out[3:2] == 2'h2;
  // count low sync cycles, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || frame_sync_n_out || !frame_sync_n_oe) begin
      low_cnt_r <= 5'h00;
    end else if (low_cnt_r != 5'h1F) begin
      low_cnt_r <= low_cnt_r + 5'h01;
    end
  end
  clock_half_a: assert property (
    debug_reset_n && $past(debug_reset_n, 4) && debug_link_clock_oe && $past(debug_link_clock_oe)
    |-> debug_link_clock_out != $past(debug_link_clock_out)) else $error("link clock not half rate");
  idle_value_a: assert property (
    trc && frame_sync_n_out |-> debug_nibble_bus_out == 4'h3 || debug_nibble_bus_out[3:2] == 2'h2)
    else $error("bad nibble with sync high");
  header_len_a: assert property (
    $rose(hdr) |=> hdr ##1 !frame_sync_n_out[*2]) else $error("header length wrong");
  sync_fall_a: assert property (
    $fell(frame_sync_n_out) && trc && $past(trc) |-> $past(debug_nibble_bus_out[3:2]) == 2'h2)
    else $error("sync low without header");
  nibble_hold_a: assert property (
    trc && $past(trc) && $changed(debug_nibble_bus_out) |=> $stable(debug_nibble_bus_out))
    else $error("nibble shorter than link period");
  frame_len_a: assert property (low_cnt_r <= 5'h10) else $error("address run too long");
  axi_write_a: assert property (
    s_awvalid && s_wvalid && !s_bvalid && !s_awready |=> s_awready && s_wready ##1 s_bvalid)
    else $error("write not answered");
  axi_read_a: assert property (
    s_arvalid && !s_rvalid && !s_arready |=> s_arready ##1 s_rvalid) else $error("read not answered");
  req_hold_a: assert property (
    mem_req_valid && !mem_ack |=> mem_req_valid && $stable(mem_req)) else $error("request dropped");
endmodule : trace_port_assertions
bind trace_port trace_port_assertions chk_i (.aclk(aclk), .aresetn(aresetn),
  .debug_reset_n(debug_reset_n), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
  .mem_ack(mem_ack), .debug_link_clock_out(debug_link_clock_out),
  .debug_link_clock_oe(debug_link_clock_oe), .frame_sync_n_out(frame_sync_n_out),
  .frame_sync_n_oe(frame_sync_n_oe), .debug_nibble_bus_out(debug_nibble_bus_out),
  .debug_nibble_bus_oe(debug_nibble_bus_oe), .s_awvalid(s_awvalid), .s_wvalid(s_wvalid),
  .s_awready(s_awready), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rvalid(s_rvalid));

// ---- test/debug_tool_model.sv ----
// debug tool model: clocks monitor frames into the port
`timescale 1ns/1ps
module debug_tool_model (
  input wire logic aclk,
  input wire logic [3:0] bus_in,
  output logic lclk,
  output logic sync_n,
  output logic [3:0] nib,
  output logic nib_oe
);
  // link clock stands high, bus released
  initial begin
    lclk = 1'b1;
    sync_n = 1'b1;
    nib = 4'h0;
    nib_oe = 1'b0;
  end
  // one link period of 8 aclk
  task automatic tick();
    lclk <= 1'b0;
    repeat (4) @(posedge aclk);
    lclk <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : tick
  task automatic put(input logic [3:0] v);
    nib <= v;
    tick();
  endtask : put
  task automatic access(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd,
                        output logic [3:0] st, output logic [31:0] rd);
    int i;
    int n;
    @(posedge aclk);
    // sync low over command, address, data
    sync_n <= 1'b0;
    nib_oe <= 1'b1;
    put(cmd);
    for (i = 0; i < 8; i++) put(addr[4 * i +: 4]);
    for (i = 0; cmd[2] && i < (2 << cmd[1:0]); i++) put(wd[4 * i +: 4]);
    nib_oe <= 1'b0;
    st = 4'h0;
    n = 0;
    // poll while busy or released
    while ((st == 4'h0 || st == 4'hF) && n < 40) begin
      tick();
      st = bus_in;
      n++;
    end
    // release sync, then clock out read data
    sync_n <= 1'b1;
    rd = 32'h0;
    repeat (4) @(posedge aclk);
    for (i = 0; st == 4'h1 && !cmd[2] && i < (2 << cmd[1:0]); i++) begin
      tick();
      rd[4 * i +: 4] = bus_in;
    end
  endtask : access
endmodule : debug_tool_model

// ---- test/trace_port_tb.sv ----
// self-checking bench for the debug port
`timescale 1ns/1ps
module trace_port_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic branch_valid = 1'b0;
  logic [31:0] branch_target = 32'h0;
  trace_port_pkg::mem_req_type mem_req, last_req;
  logic mem_req_valid, lc_out, lc_oe, fs_out, fs_oe, nb_oe, t_clk, t_sync, t_oe;
  logic mem_ack = 1'b0;
  logic mem_err = 1'b0;
  logic [31:0] mem_rdata = 32'h5A5AC3C3;
  logic debug_reset_n = 1'b0;
  logic debug_mode_select = 1'b1;
  logic [3:0] nb_out, t_nib, st;
  logic [3:0] s_awaddr = 4'h0;
  logic [3:0] s_araddr = 4'h0;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic [31:0] s_rdata, d;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  // resolved pins, pulled up where released
  wire lclk = lc_oe ? lc_out : t_clk;
  wire fsync = fs_oe ? fs_out : t_sync;
  wire [3:0] nbus = nb_oe ? nb_out : (t_oe ? t_nib : 4'hF);
  // branch rows: target and size code against the previous target
  logic [31:0] tgt [4] = '{32'h00000005, 32'h00000036, 32'h00001237, 32'h80000000};
  logic [1:0] code [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  // monitor rows: command, address, status
  logic [3:0] mcmd [5] = '{4'hA, 4'hE, 4'hB, 4'h9, 4'hA};
  logic [31:0] madr [5] = '{32'h00001000, 32'h00002000, 32'h00001000, 32'h00000001, 32'hFFFFF000};
  logic [3:0] mst [5] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h4};
  trace_port DUT (.aclk(aclk), .aresetn(aresetn), .branch_valid(branch_valid),
    .branch_target(branch_target), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata), .debug_reset_n(debug_reset_n),
    .debug_mode_select(debug_mode_select), .debug_link_clock_in(lclk),
    .debug_link_clock_out(lc_out), .debug_link_clock_oe(lc_oe), .frame_sync_n_in(fsync),
    .frame_sync_n_out(fs_out), .frame_sync_n_oe(fs_oe), .debug_nibble_bus_in(nbus),
    .debug_nibble_bus_out(nb_out), .debug_nibble_bus_oe(nb_oe), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  debug_tool_model tool (.aclk(aclk), .bus_in(nbus), .lclk(t_clk), .sync_n(t_sync),
    .nib(t_nib), .nib_oe(t_oe));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // system bus answers one cycle later; timeout guard
  always @(posedge aclk) begin
    mem_ack <= mem_req_valid && !mem_ack;
    if (mem_req_valid) last_req <= mem_req;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_rd
  task automatic pulse(input logic [31:0] t);
    @(posedge aclk);
    branch_target <= t;
    branch_valid <= 1'b1;
    @(posedge aclk);
    branch_valid <= 1'b0;
  endtask : pulse
  // mode changes only under debug reset
  task automatic set_mode(input logic m);
    @(posedge aclk);
    debug_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    debug_mode_select <= m;
    repeat (4) @(posedge aclk);
    debug_reset_n <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : set_mode
  task automatic trace_chk(input logic [31:0] t, input logic [1:0] c);
    int n;
    int k;
    n = 0;
    while (!(fs_out && nb_out[3:2] == 2'h2) && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk(n >= 4 && n <= 5, 1);
    chk(nb_out, {2'h2, c});
    while (fs_out) @(posedge aclk);
    for (k = 0; k < (1 << c); k++) begin
      chk(nb_out, (t >> (4 * k)) & 32'hF);
      repeat (2) @(posedge aclk);
    end
    chk({fs_out, nb_out}, 5'h13);
  endtask : trace_chk
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h8);
    chk(d, 32'h0);
    axi_rd(4'hC);
    chk(r, 2'h2);
    axi_wr(4'h0, 32'h2);
    chk(r, 2'h0);
    set_mode(1'b0);
    chk({fs_out, nb_out}, 5'h13);
    for (int i = 0; i < 4; i++) begin
      pulse(tgt[i]);
      trace_chk(tgt[i], code[i]);
      axi_rd(4'h8);
      chk(d, tgt[i]);
    end
    // abort mid address, size taken from last complete target
    pulse(32'h12345678);
    while (fs_out) @(posedge aclk);
    repeat (4) @(posedge aclk);
    pulse(32'h80000001);
    trace_chk(32'h80000001, 2'h0);
    set_mode(1'b1);
    for (int i = 0; i < 5; i++) begin
      tool.access(mcmd[i], madr[i], 32'h89ABCDEF, st, d);
      chk(st, mst[i]);
      chk(st[3], 1'b0);
      if (i < 2) chk(last_req.addr, madr[i]);
      if (i < 2) chk({last_req.write, last_req.size}, mcmd[i][2:0]);
    end
    tool.access(4'hA, 32'h00001000, 32'h0, st, d);
    chk(d, mem_rdata);
    tool.access(4'hE, 32'h00002000, 32'h89ABCDEF, st, d);
    chk(last_req.wdata, 32'h89ABCDEF);
    // system bus reports an error with its answer
    mem_err <= 1'b1;
    tool.access(4'hA, 32'h00001000, 32'h0, st, d);
    chk(st, 4'h4);
    mem_err <= 1'b0;
    // single chip: external space refused
    axi_wr(4'h0, 32'h3);
    axi_rd(4'h0);
    chk(d, 32'h3);
    tool.access(4'h8, 32'h00400000, 32'h0, st, d);
    chk(st, 4'h4);
    close_out();
  end
endmodule : trace_port_tb
